// File: pkg/i2c_hold_defines.vh
// Constants for the I2C slave hold and control block
`ifndef I2C_HOLD_DEFINES_VH
`define I2C_HOLD_DEFINES_VH
// ****************************************
// Register map
// ****************************************
`define ADDR_W 4
`define ADDR_CTRL3 4'h0
`define ADDR_CTRL1 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_CLEAR 4'h3
`define ADDR_ENABLE 4'h4
`define ADDR_RXBUF 4'h5
// ****************************************
// Control three fields
// ****************************************
`define CTRL3_RESET 8'h00
`define CTRL3_WMASK 8'h7F
`define BIT_ACK 7
`define BIT_PCIE 6
`define BIT_START_IRQ_ENABLE 5
`define BIT_BUFFER_OVERWRITE_ENABLE 4
`define BIT_SDA_HOLD_SELECT 3
`define BIT_SLAVE_COLLISION_DETECT_ENABLE 2
`define BIT_ADDRESS_HOLD_ENABLE 1
`define BIT_DATA_HOLD_ENABLE 0
// Control one: bit 4 clock release, bit 6 overflow, bits 3:0 mode
`define BIT_CREL 4
`define BIT_OVF 6
`define MODE_LSB 0
`define MODE_MSB 3
`define CTRL1_RESET 8'h10
// Modes with start and stop interrupt events always on
`define MODE_SS_A 4'hE
`define MODE_SS_B 4'hF
// ****************************************
// Status / interrupt bits
// ****************************************
`define IRQ_W 5
`define IRQ_START 0
`define IRQ_STOP 1
`define IRQ_BYTE 2
`define IRQ_COLL 3
`define IRQ_HOLD 4
// ****************************************
// Timing
// ****************************************
`define CLK_NS 8
`define HOLD_LONG_NS 300
`define HOLD_SHORT_NS 100
// Hold counts: hold time over clock period, rounded up
`define HOLD_LONG_CYC 6'h26
`define HOLD_SHORT_CYC 6'h0D
`define HCNT_W 6
`define BITS_PER_BYTE 4'h8
`define ACK_BIT 4'h9
// Bit count after a start; the start's own SCL fall wraps it to zero
`define CNT_PRE 4'hF
`endif

// File: hw/i2c_slave_hold_control.v
// I2C slave hold, acknowledge phase, overwrite and collision control
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "i2c_hold_defines.vh"
module i2c_slave_hold_control (
	// Clock and reset
	input wire clk_sys_i,
	input wire rstn_i,
	// Register port
	input wire [`ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Byte engine side
	input wire addr_match_i,
	input wire [7:0] rx_byte_i,
	input wire sda_out_i,
	// Bus pins
	input wire scl_i,
	input wire sda_i,
	output wire scl_o,
	output wire scl_oe_o,
	output wire sda_o,
	output wire sda_oe_o,
	// Interrupt
	output wire irq_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg scl_m_reg;
	reg scl_s_reg;
	reg scl_d_reg;
	reg sda_m_reg;
	reg sda_s_reg;
	reg sda_d_reg;
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_i;
			scl_s_reg <= scl_m_reg;
			scl_d_reg <= scl_s_reg;
			sda_m_reg <= sda_i;
			sda_s_reg <= sda_m_reg;
			sda_d_reg <= sda_s_reg;
		end
	end
	// ****************************************
	// Edge and condition detection
	// ****************************************
	wire scl_rise = scl_s_reg & ~scl_d_reg;
	wire scl_fall = ~scl_s_reg & scl_d_reg;
	wire start_det = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
	wire stop_det = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] ctrl3_reg;
	reg [7:0] ctrl1_reg;
	reg [7:0] rxbuf_reg;
	reg [`IRQ_W-1:0] status_reg;
	reg [`IRQ_W-1:0] enable_reg;
	reg [3:0] bitcnt_reg;
	reg first_byte_reg;
	reg in_frame_reg;
	reg stretch_reg;
	reg [`HCNT_W-1:0] hcnt_reg;
	reg sda_drv_reg;
	wire [3:0] mode = ctrl1_reg[`MODE_MSB:`MODE_LSB];
	// Start/stop interrupt events permanently on in these modes
	function ss_forced;
		input [3:0] m;
		begin
			ss_forced = (m == `MODE_SS_A) || (m == `MODE_SS_B);
		end
	endfunction
	// ****************************************
	// Byte events
	// ****************************************
	// The bit counter excludes the start's SCL fall, so counts are data bits
	wire eighth_fall = scl_fall & (bitcnt_reg == `BITS_PER_BYTE - 4'h1) & in_frame_reg;
	wire ninth_rise = scl_rise & (bitcnt_reg == `BITS_PER_BYTE);
	wire byte_done = eighth_fall;
	wire hold_addr = byte_done & first_byte_reg & addr_match_i & ctrl3_reg[`BIT_ADDRESS_HOLD_ENABLE];
	wire hold_data = byte_done & ~first_byte_reg & ctrl3_reg[`BIT_DATA_HOLD_ENABLE];
	wire coll = ctrl3_reg[`BIT_SLAVE_COLLISION_DETECT_ENABLE] & scl_rise & sda_drv_reg & sda_out_i & ~sda_s_reg;
	wire buf_load = byte_done & (ctrl3_reg[`BIT_BUFFER_OVERWRITE_ENABLE] | ~ctrl1_reg[`BIT_OVF]);
	wire ovf_set = byte_done & ctrl1_reg[`BIT_OVF] & ~ctrl3_reg[`BIT_BUFFER_OVERWRITE_ENABLE];
	wire start_en = ctrl3_reg[`BIT_START_IRQ_ENABLE] | ss_forced(mode);
	wire stop_en = ctrl3_reg[`BIT_PCIE] | ss_forced(mode);
	reg [`IRQ_W-1:0] ev;
	always @* begin
		ev = {`IRQ_W{1'b0}};
		ev[`IRQ_START] = start_det & start_en;
		ev[`IRQ_STOP] = stop_det & stop_en;
		ev[`IRQ_BYTE] = byte_done;
		ev[`IRQ_COLL] = coll;
		ev[`IRQ_HOLD] = hold_addr | hold_data;
	end
	wire wr_clr = wr_i & (addr_i == `ADDR_CLEAR);
	wire [7:0] ctrl3_wval = wdata_i & `CTRL3_WMASK;
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ctrl3_reg <= `CTRL3_RESET;
			ctrl1_reg <= `CTRL1_RESET;
			rxbuf_reg <= 8'h00;
			status_reg <= {`IRQ_W{1'b0}};
			enable_reg <= {`IRQ_W{1'b0}};
		end else begin
			if (wr_i && addr_i == `ADDR_CTRL3) begin
				ctrl3_reg[`BIT_PCIE:0] <= ctrl3_wval[`BIT_PCIE:0];
			end
			if (eighth_fall) begin
				ctrl3_reg[`BIT_ACK] <= 1'b1;
			end else if (ninth_rise) begin
				ctrl3_reg[`BIT_ACK] <= 1'b0;
			end
			if (wr_i && addr_i == `ADDR_CTRL1) begin
				ctrl1_reg <= wdata_i;
			end
			if (hold_addr) begin
				ctrl1_reg[`BIT_CREL] <= 1'b0;
			end else if (hold_data) begin
				ctrl1_reg[`BIT_CREL] <= 1'b0;
			end
			if (ovf_set) begin
				ctrl1_reg[`BIT_OVF] <= 1'b1;
			end
			if (buf_load) begin
				rxbuf_reg <= rx_byte_i;
			end
			if (wr_i && addr_i == `ADDR_ENABLE) begin
				enable_reg <= wdata_i[`IRQ_W-1:0];
			end
			// Set wins over clear
			status_reg <= (status_reg & ~(wr_clr ? wdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | ev;
		end
	end
	// ****************************************
	// Bit counting and stretching
	// ****************************************
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			bitcnt_reg <= 4'h0;
			first_byte_reg <= 1'b0;
			in_frame_reg <= 1'b0;
			stretch_reg <= 1'b0;
		end else begin
			if (start_det) begin
				bitcnt_reg <= `CNT_PRE;
				first_byte_reg <= 1'b1;
				in_frame_reg <= 1'b1;
			end else if (stop_det) begin
				in_frame_reg <= 1'b0;
				stretch_reg <= 1'b0;
			end else if (scl_fall && in_frame_reg) begin
				if (bitcnt_reg == `ACK_BIT - 4'h1) begin
					bitcnt_reg <= 4'h0;
					first_byte_reg <= 1'b0;
				end else begin
					bitcnt_reg <= bitcnt_reg + 4'h1;
				end
			end
			if (hold_addr || hold_data) begin
				stretch_reg <= 1'b1;
			end else if (ctrl1_reg[`BIT_CREL]) begin
				stretch_reg <= 1'b0;
			end
		end
	end
	assign scl_o = 1'b0;
	assign scl_oe_o = stretch_reg;
	// ****************************************
	// SDA hold time
	// ****************************************
	// Reloaded on every fall: a fast SCL keeps SDA frozen until it slows
	wire [`HCNT_W-1:0] hold_cyc = ctrl3_reg[`BIT_SDA_HOLD_SELECT] ? `HOLD_LONG_CYC : `HOLD_SHORT_CYC;
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			hcnt_reg <= {`HCNT_W{1'b0}};
			sda_drv_reg <= 1'b1;
		end else if (scl_fall) begin
			hcnt_reg <= hold_cyc;
		end else if (hcnt_reg != {`HCNT_W{1'b0}}) begin
			hcnt_reg <= hcnt_reg - {{(`HCNT_W-1){1'b0}}, 1'b1};
		end else begin
			sda_drv_reg <= sda_out_i;
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_o = ~sda_drv_reg;
	// ****************************************
	// Interrupt output
	// ****************************************
	assign irq_o = |(status_reg & enable_reg);
	// ****************************************
	// Read port
	// ****************************************
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`ADDR_CTRL3: rdata_o <= ctrl3_reg;
				`ADDR_CTRL1: rdata_o <= ctrl1_reg;
				`ADDR_STATUS: rdata_o <= {{(8-`IRQ_W){1'b0}}, status_reg};
				`ADDR_ENABLE: rdata_o <= {{(8-`IRQ_W){1'b0}}, enable_reg};
				`ADDR_RXBUF: rdata_o <= rxbuf_reg;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// File: tb/hold_checker.sv
// Assertion checker for the hold control block
`timescale 1ns/10ps
module hold_checker (
	// Clock and reset
	input wire clk_sys_i,
	input wire rstn_i,
	// Register port
	input wire rd_i,
	input wire wr_i,
	input wire [7:0] rdata_o,
	// Pins and interrupt
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe_o,
	input wire sda_o,
	input wire sda_oe_o,
	input wire irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_hold_frozen: assert property ($fell(scl_i) |-> ##4 $stable(sda_oe_o)[*8])
		else $error("sda moved inside hold time");
	a_stretch_low: assert property ($rose(scl_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("stretch began with scl high");
	a_stretch_keep: assert property (scl_oe_o && !wr_i && !$past(wr_i) |=> scl_oe_o)
		else $error("stretch ended without release");
	a_pins_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("pin output level not low");
	a_irq_reset: assert property ($rose(rstn_i) |-> !irq_o)
		else $error("interrupt high after reset");
endmodule

// File: tb/i2c_master_model.sv
// Behavioural I2C bus master, open-drain low drivers
`timescale 1ns/10ps
module i2c_master_model (
	// Wired bus levels
	input wire scl_w,
	// Low drivers
	output reg scl_low,
	output reg sda_low
);
	integer n;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task start;
		begin
			sda_low = 1'b1;
			#40 scl_low = 1'b1;
			#20;
		end
	endtask
	// One bit, waits while the slave stretches SCL
	task clk_bit(input b);
		begin
			sda_low = !b;
			#20 scl_low = 1'b0;
			n = 0;
			while (!scl_w && n < 500) begin
				#8 n = n + 1;
			end
			#40 scl_low = 1'b1;
			#20;
		end
	endtask
	task send_byte(input [7:0] d);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) clk_bit(d[i]);
		end
	endtask
	task stop;
		begin
			sda_low = 1'b1;
			#20 scl_low = 1'b0;
			#40 sda_low = 1'b0;
			#20;
		end
	endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the hold control block
`timescale 1ns/10ps
`include "i2c_hold_defines.vh"
module tb;
	reg clk_sys_i = 1'b0;
	reg rstn_i = 1'b0;
	reg [3:0] addr_i = 4'h0;
	reg [7:0] wdata_i = 8'h00;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg addr_match_i = 1'b0;
	reg [7:0] rx_byte_i = 8'h00;
	reg sda_out_i = 1'b1;
	wire [7:0] rdata_o;
	wire scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl, m_sda;
	wire scl_w = !(m_scl | scl_oe_o);
	wire sda_w = !(m_sda | sda_oe_o);
	integer bad_count = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	i2c_slave_hold_control i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.addr_match_i(addr_match_i), .rx_byte_i(rx_byte_i), .sda_out_i(sda_out_i),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .irq_o(irq_o));
	i2c_master_model i_mst (.scl_w(scl_w), .scl_low(m_scl), .sda_low(m_sda));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk_sys_i);
			addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
			@(posedge clk_sys_i);
			wr_i <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge clk_sys_i);
			addr_i <= a; rd_i <= 1'b1;
			@(posedge clk_sys_i);
			rd_i <= 1'b0;
			#1 chk(rdata_o, e);
		end
	endtask
	task final_report;
		begin
			if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd(`ADDR_CTRL3, 8'h00);
		rd(`ADDR_CTRL1, 8'h10);
		rd(4'hF, 8'h00);
		wr(`ADDR_CTRL3, 8'hFF);
		rd(`ADDR_CTRL3, 8'h7F);
		wr(`ADDR_CTRL3, 8'h02);
		wr(`ADDR_ENABLE, 8'h04);
		addr_match_i <= 1'b1; rx_byte_i <= 8'hA4;
		i_mst.start;
		i_mst.send_byte(8'hA4);
		repeat (8) @(posedge clk_sys_i);
		rd(`ADDR_CTRL3, 8'h82);
		rd(`ADDR_CTRL1, 8'h00);
		chk({6'h00, scl_oe_o, irq_o}, 8'h03);
		wr(`ADDR_CLEAR, 8'h04);
		#1 chk({6'h00, scl_oe_o, irq_o}, 8'h02);
		wr(`ADDR_CTRL1, 8'h10);
		i_mst.clk_bit(1'b1);
		rd(`ADDR_CTRL3, 8'h02);
		rd(`ADDR_RXBUF, 8'hA4);
		wr(`ADDR_CTRL3, 8'h01);
		wr(`ADDR_ENABLE, 8'h00);
		wr(`ADDR_CTRL1, 8'h50);
		rx_byte_i <= 8'h5A;
		i_mst.send_byte(8'h5A);
		repeat (8) @(posedge clk_sys_i);
		rd(`ADDR_CTRL1, 8'h40);
		rd(`ADDR_RXBUF, 8'hA4);
		chk({7'h00, irq_o}, 8'h00);
		wr(`ADDR_CTRL3, 8'h1D);
		wr(`ADDR_CTRL1, 8'h50);
		i_mst.clk_bit(1'b1);
		rx_byte_i <= 8'hC3;
		i_mst.send_byte(8'hC3);
		repeat (8) @(posedge clk_sys_i);
		rd(`ADDR_RXBUF, 8'hC3);
		rd(`ADDR_STATUS, 8'h1C);
		wr(`ADDR_CTRL1, 8'h50);
		i_mst.clk_bit(1'b1);
		@(posedge clk_sys_i);
		sda_out_i <= 1'b0;
		repeat (30) @(posedge clk_sys_i);
		#1 chk({7'h00, sda_oe_o}, 8'h00);
		repeat (15) @(posedge clk_sys_i);
		#1 chk({7'h00, sda_oe_o}, 8'h01);
		wr(`ADDR_CTRL1, 8'h5E);
		sda_out_i <= 1'b1;
		i_mst.stop;
		rd(`ADDR_STATUS, 8'h1E);
		final_report;
	end
endmodule
bind i2c_slave_hold_control hold_checker i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
	.rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
